// ===== fieldbus_diag_status_bank.sv
// Behaviour
// - NMT state reads as 16-bit code 0 boot, 1 oper, 2 stopped, 4 preop.
// - Any NMT state change while motor runs raises the comm-interrupt error.
// - Transmit object count is a read-only 16-bit value.
// - Receive object count is a read-only 16-bit value.
// - Last-error holds newest error code 0..5; 0 after communication start.
// - Bus-off loads error code 1.
// - Node-guarding failure loads error code 2.
// - CAN overrun loads error code 3.
// - Heartbeat failure loads error code 4.
// - Illegal NMT state-chart transition loads error code 5.
// - Receive error counter of the CAN controller mirrored read-only.
// - Transmit error counter of the CAN controller mirrored read-only.
// - Restart command returns to no-restart once restart completes.
// - Restart does fault reset first, then a power-cycle-like sequence.
// - Freewheel mode: comm failure raises comm-interrupt error and coasts motor.
module fieldbus_diag_status_bank (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Parameter access by logic address
   input wire logic param_req,
   input wire logic param_we,
   input wire logic [15:0] param_addr,
   input wire logic [15:0] param_wdata,
   output logic [15:0] param_rdata,
   output logic param_ack,
   output logic param_err,
   // Protocol engine
   input wire logic [1:0] nmt_state,
   input wire logic [15:0] tx_pdo_count,
   input wire logic [15:0] rx_pdo_count,
   input wire logic comm_start,
   input wire logic bus_off_event,
   input wire logic overrun_event,
   input wire logic guard_fail_event,
   input wire logic heartbeat_fail_event,
   input wire logic nmt_chart_event,
   input wire logic comm_failure_event,
   input wire logic boot_complete,
   // CAN controller counters
   input wire logic [15:0] can_rx_err_cnt,
   input wire logic [15:0] can_tx_err_cnt,
   // Motor control
   input wire logic motor_running,
   input wire logic [2:0] error_resp_mode,
   // Status and sequence outputs
   output logic comm_interrupt_error,
   output logic coast_stop,
   output logic fault_reset,
   output logic node_reset,
   output logic restart_busy
);

   // ************************************************
   // Register storage
   // ************************************************
   logic [15:0] last_comm_error_code;
   logic [15:0] network_mgmt_state;
   logic [15:0] tx_error_count;
   logic [15:0] rx_error_count;
   logic [15:0] restart_command;
   logic [15:0] tx_object_count;
   logic [15:0] rx_object_count;

   logic [15:0] next_error_code;
   logic [15:0] next_nmt_code;
   logic [1:0] nmt_prev;
   logic nmt_changed;
   logic freewheel_fail;
   logic any_error_event;
   logic addr_hit;
   logic addr_writable;
   logic restart_write;
   logic restart_done;
   logic [15:0] next_rdata;

   // ************************************************
   // Network management state
   // ************************************************
   always_comb begin
      case (fieldbus_diag_pkg::nmt_in_t'(nmt_state))
         fieldbus_diag_pkg::NMT_IN_BOOT: next_nmt_code = fieldbus_diag_pkg::NMT_CODE_BOOT;
         fieldbus_diag_pkg::NMT_IN_OPER: next_nmt_code = fieldbus_diag_pkg::NMT_CODE_OPER;
         fieldbus_diag_pkg::NMT_IN_STOPPED: next_nmt_code = fieldbus_diag_pkg::NMT_CODE_STOPPED;
         fieldbus_diag_pkg::NMT_IN_PREOP: next_nmt_code = fieldbus_diag_pkg::NMT_CODE_PREOP;
         default: next_nmt_code = fieldbus_diag_pkg::NMT_CODE_BOOT;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         network_mgmt_state <= fieldbus_diag_pkg::NMT_CODE_BOOT;
         nmt_prev <= 2'h0;
      end else begin
         network_mgmt_state <= next_nmt_code;
         nmt_prev <= nmt_state;
      end
   end

   // Previous state seeded to boot so the first post-reset step counts
   assign nmt_changed = (nmt_state != nmt_prev);

   // ************************************************
   // Mirrored counters
   // ************************************************
   // Sampled every cycle; writes never reach these
   always_ff @(posedge mclk) begin
      if (rst) begin
         tx_object_count <= fieldbus_diag_pkg::RESET_WORD;
         rx_object_count <= fieldbus_diag_pkg::RESET_WORD;
      end else begin
         tx_object_count <= tx_pdo_count;
         rx_object_count <= rx_pdo_count;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rx_error_count <= fieldbus_diag_pkg::RESET_WORD;
         tx_error_count <= fieldbus_diag_pkg::RESET_WORD;
      end else begin
         rx_error_count <= can_rx_err_cnt;
         tx_error_count <= can_tx_err_cnt;
      end
   end

   // ************************************************
   // Last communication error
   // ************************************************
   // Simultaneous events: highest code wins, events beat the clear
   always_comb begin
      if (nmt_chart_event) begin
         next_error_code = fieldbus_diag_pkg::ERR_NMT_CHART;
      end else if (heartbeat_fail_event) begin
         next_error_code = fieldbus_diag_pkg::ERR_HEARTBEAT;
      end else if (overrun_event) begin
         next_error_code = fieldbus_diag_pkg::ERR_OVERRUN;
      end else if (guard_fail_event) begin
         next_error_code = fieldbus_diag_pkg::ERR_GUARD;
      end else if (bus_off_event) begin
         next_error_code = fieldbus_diag_pkg::ERR_BUS_OFF;
      end else begin
         next_error_code = fieldbus_diag_pkg::ERR_NONE;
      end
   end

   assign any_error_event = nmt_chart_event || heartbeat_fail_event ||
                            overrun_event || guard_fail_event || bus_off_event;

   always_ff @(posedge mclk) begin
      if (rst) begin
         last_comm_error_code <= fieldbus_diag_pkg::ERR_NONE;
      end else if (any_error_event) begin
         last_comm_error_code <= next_error_code;
      end else if (comm_start) begin
         last_comm_error_code <= fieldbus_diag_pkg::ERR_NONE;
      end
   end

   // ************************************************
   // Communication interrupt error and coast stop
   // ************************************************
   assign freewheel_fail = comm_failure_event &&
      (error_resp_mode == fieldbus_diag_pkg::RESP_FREEWHEEL);

   // Latched until the fault reset of a restart; a new cause wins
   always_ff @(posedge mclk) begin
      if (rst) begin
         comm_interrupt_error <= 1'b0;
      end else if ((motor_running && nmt_changed) || freewheel_fail) begin
         comm_interrupt_error <= 1'b1;
      end else if (fault_reset) begin
         comm_interrupt_error <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         coast_stop <= 1'b0;
      end else if (freewheel_fail) begin
         coast_stop <= 1'b1;
      end else if (fault_reset) begin
         coast_stop <= 1'b0;
      end
   end

   // ************************************************
   // Parameter access
   // ************************************************
   always_comb begin
      addr_hit = 1'b1;
      addr_writable = 1'b0;
      next_rdata = 16'h0000;
      case (param_addr)
         fieldbus_diag_pkg::ADDR_LAST_ERR: next_rdata = last_comm_error_code;
         fieldbus_diag_pkg::ADDR_NMT_STATE: next_rdata = network_mgmt_state;
         fieldbus_diag_pkg::ADDR_TX_ERR_CNT: next_rdata = tx_error_count;
         fieldbus_diag_pkg::ADDR_RX_ERR_CNT: next_rdata = rx_error_count;
         fieldbus_diag_pkg::ADDR_TX_OBJ_CNT: next_rdata = tx_object_count;
         fieldbus_diag_pkg::ADDR_RX_OBJ_CNT: next_rdata = rx_object_count;
         fieldbus_diag_pkg::ADDR_RESTART: begin
            next_rdata = restart_command;
            addr_writable = 1'b1;
         end
         default: addr_hit = 1'b0;
      endcase
   end

   // Only the restart word is writable; others refuse with an error
   assign restart_write = param_req && param_we && addr_writable;

   always_ff @(posedge mclk) begin
      if (rst) begin
         param_ack <= 1'b0;
         param_err <= 1'b0;
         param_rdata <= 16'h0000;
      end else begin
         param_ack <= param_req;
         param_err <= param_req && (!addr_hit || (param_we && !addr_writable));
         if (param_req && !param_we) begin
            param_rdata <= next_rdata;
         end
      end
   end

   // ************************************************
   // Product restart
   // ************************************************
   // A second yes while busy is absorbed; no cannot abort a restart
   always_ff @(posedge mclk) begin
      if (rst) begin
         restart_command <= fieldbus_diag_pkg::RESTART_NO;
      end else if (restart_done) begin
         restart_command <= fieldbus_diag_pkg::RESTART_NO;
      end else if (restart_write && !restart_busy &&
                   param_wdata == fieldbus_diag_pkg::RESTART_YES) begin
         restart_command <= fieldbus_diag_pkg::RESTART_YES;
      end
   end

   restart_seq u_restart_seq (
      .mclk(mclk),
      .rst(rst),
      .start(restart_command == fieldbus_diag_pkg::RESTART_YES && !restart_busy && !restart_done),
      .boot_complete(boot_complete),
      .fault_reset(fault_reset),
      .node_reset(node_reset),
      .busy(restart_busy),
      .done(restart_done)
   );

   // ************************************************
   // Checks
   // ************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   sequence s_yes_written;
      param_req && param_we && param_addr == fieldbus_diag_pkg::ADDR_RESTART &&
      param_wdata == fieldbus_diag_pkg::RESTART_YES && !restart_busy && !restart_done;
   endsequence

   sequence s_fault_then_hold;
      fault_reset ##1 node_reset;
   endsequence

   a_nmt_code_map: assert property (
      nmt_state == fieldbus_diag_pkg::NMT_IN_PREOP |=>
      network_mgmt_state == fieldbus_diag_pkg::NMT_CODE_PREOP)
      else $error("NMT preop code wrong");

   a_nmt_run_change: assert property (
      motor_running && nmt_changed |=> comm_interrupt_error)
      else $error("NMT change while running not flagged");

   a_obj_counts: assert property (
      1'b1 |=> tx_object_count == $past(tx_pdo_count) &&
               rx_object_count == $past(rx_pdo_count))
      else $error("Object count mirror wrong");

   a_err_range: assert property (
      last_comm_error_code <= fieldbus_diag_pkg::ERR_NMT_CHART)
      else $error("Error code out of range");

   a_start_clears: assert property (
      comm_start && !any_error_event |=> last_comm_error_code == fieldbus_diag_pkg::ERR_NONE)
      else $error("Communication start did not clear error");

   a_bus_off_code: assert property (
      bus_off_event && !guard_fail_event && !overrun_event &&
      !heartbeat_fail_event && !nmt_chart_event |=>
      last_comm_error_code == fieldbus_diag_pkg::ERR_BUS_OFF)
      else $error("Bus-off code wrong");

   a_guard_code: assert property (
      guard_fail_event && !overrun_event && !heartbeat_fail_event && !nmt_chart_event |=>
      last_comm_error_code == fieldbus_diag_pkg::ERR_GUARD)
      else $error("Guarding code wrong");

   a_overrun_code: assert property (
      overrun_event && !heartbeat_fail_event && !nmt_chart_event |=>
      last_comm_error_code == fieldbus_diag_pkg::ERR_OVERRUN)
      else $error("Overrun code wrong");

   a_heartbeat_code: assert property (
      heartbeat_fail_event && !nmt_chart_event |=>
      last_comm_error_code == fieldbus_diag_pkg::ERR_HEARTBEAT)
      else $error("Heartbeat code wrong");

   a_chart_code: assert property (
      nmt_chart_event |=> last_comm_error_code == fieldbus_diag_pkg::ERR_NMT_CHART)
      else $error("State chart code wrong");

   a_err_counters: assert property (
      1'b1 |=> rx_error_count == $past(can_rx_err_cnt) &&
               tx_error_count == $past(can_tx_err_cnt))
      else $error("Error counter mirror wrong");

   a_restart_clears: assert property (
      restart_done |=> restart_command == fieldbus_diag_pkg::RESTART_NO && !restart_busy)
      else $error("Restart command not cleared");

   a_restart_order: assert property (
      s_yes_written |=> ##1 s_fault_then_hold)
      else $error("Restart did not fault-reset then hold");

   a_hold_length: assert property (
      $rose(node_reset) |-> node_reset [*8])
      else $error("Reset hold too short");

   a_freewheel_stop: assert property (
      freewheel_fail |=> comm_interrupt_error && coast_stop)
      else $error("Freewheel failure not handled");

   a_ro_write_err: assert property (
      param_req && param_we && param_addr == fieldbus_diag_pkg::ADDR_LAST_ERR &&
      !any_error_event && !comm_start |=> param_err && $stable(last_comm_error_code))
      else $error("Read-only write not refused");

endmodule

// ===== fieldbus_diag_pkg.sv
package fieldbus_diag_pkg;

   // ************************************************
   // Parameter logic addresses
   // ************************************************
   localparam logic [15:0] ADDR_LAST_ERR = 16'h17A8;
   localparam logic [15:0] ADDR_NMT_STATE = 16'h17A9;
   localparam logic [15:0] ADDR_TX_ERR_CNT = 16'h17AA;
   localparam logic [15:0] ADDR_RX_ERR_CNT = 16'h17AB;
   localparam logic [15:0] ADDR_RESTART = 16'h1BD8;
   localparam logic [15:0] ADDR_TX_OBJ_CNT = 16'h330E;
   localparam logic [15:0] ADDR_RX_OBJ_CNT = 16'h330F;

   // ************************************************
   // Reported state and error codes
   // ************************************************
   localparam logic [15:0] NMT_CODE_BOOT = 16'h0000;
   localparam logic [15:0] NMT_CODE_OPER = 16'h0001;
   localparam logic [15:0] NMT_CODE_STOPPED = 16'h0002;
   localparam logic [15:0] NMT_CODE_PREOP = 16'h0004;

   localparam logic [15:0] ERR_NONE = 16'h0000;
   localparam logic [15:0] ERR_BUS_OFF = 16'h0001;
   localparam logic [15:0] ERR_GUARD = 16'h0002;
   localparam logic [15:0] ERR_OVERRUN = 16'h0003;
   localparam logic [15:0] ERR_HEARTBEAT = 16'h0004;
   localparam logic [15:0] ERR_NMT_CHART = 16'h0005;

   localparam logic [15:0] RESTART_NO = 16'h0000;
   localparam logic [15:0] RESTART_YES = 16'h0001;

   // ************************************************
   // Reset values
   // ************************************************
   localparam logic [15:0] RESET_WORD = 16'h0000;

   // ************************************************
   // Timing
   // ************************************************
   localparam int CLK_HZ = 50_000_000;
   localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
   localparam int RESTART_HOLD_NS = 1000;
   localparam int RESTART_HOLD_CYC = (RESTART_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_W = 8;

   // ************************************************
   // Types
   // ************************************************
   typedef enum logic [1:0] {
      NMT_IN_BOOT,
      NMT_IN_OPER,
      NMT_IN_STOPPED,
      NMT_IN_PREOP
   } nmt_in_t;

   typedef enum logic [2:0] {
      RESP_IGNORE,
      RESP_FREEWHEEL,
      RESP_CONFIGURED,
      RESP_DECEL,
      RESP_BRAKING
   } resp_mode_t;

endpackage

// ===== restart_seq.sv
module restart_seq (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Control
   input wire logic start,
   input wire logic boot_complete,
   // Sequence outputs
   output logic fault_reset,
   output logic node_reset,
   output logic busy,
   output logic done
);

   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_FAULT_RST,
      SEQ_HOLD,
      SEQ_WAIT_BOOT
   } seq_state_t;

   seq_state_t state;
   logic [fieldbus_diag_pkg::HOLD_W-1:0] hold_cnt;

   localparam logic [fieldbus_diag_pkg::HOLD_W-1:0] HOLD_LAST =
      fieldbus_diag_pkg::HOLD_W'(fieldbus_diag_pkg::RESTART_HOLD_CYC - 1);

   // Fault reset first, then a power-cycle-like hold, then reboot
   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= SEQ_IDLE;
      end else begin
         case (state)
            SEQ_IDLE: begin
               if (start) begin
                  state <= SEQ_FAULT_RST;
               end
            end
            SEQ_FAULT_RST: begin
               state <= SEQ_HOLD;
            end
            SEQ_HOLD: begin
               if (hold_cnt == HOLD_LAST) begin
                  state <= SEQ_WAIT_BOOT;
               end
            end
            SEQ_WAIT_BOOT: begin
               if (boot_complete) begin
                  state <= SEQ_IDLE;
               end
            end
            default: begin
               state <= SEQ_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst || state != SEQ_HOLD) begin
         hold_cnt <= '0;
      end else begin
         hold_cnt <= hold_cnt + 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         fault_reset <= 1'b0;
         node_reset <= 1'b0;
         done <= 1'b0;
      end else begin
         fault_reset <= (state == SEQ_IDLE) && start;
         node_reset <= (state == SEQ_FAULT_RST) ||
                       ((state == SEQ_HOLD) && (hold_cnt != HOLD_LAST));
         done <= (state == SEQ_WAIT_BOOT) && boot_complete;
      end
   end

   assign busy = (state != SEQ_IDLE);

endmodule

// ===== param_master.sv
module param_master (
   // Clock
   input wire logic mclk,
   // Parameter port
   output logic param_req,
   output logic param_we,
   output logic [15:0] param_addr,
   output logic [15:0] param_wdata,
   input wire logic [15:0] param_rdata,
   input wire logic param_ack,
   input wire logic param_err
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      param_req = 1'b0;
      param_we = 1'b0;
      param_addr = 16'h0000;
      param_wdata = 16'h0000;
   end

   // ************************************************
   // One access: single request pulse, answer one cycle later
   // ************************************************
   // Called just after a rising edge; returns just after the answer edge
   task automatic xfer(input logic we, input logic [15:0] addr, input logic [15:0] wdata,
                       output logic [15:0] rdata, output logic ack, output logic err);
      param_req = 1'b1;
      param_we = we;
      param_addr = addr;
      param_wdata = wdata;
      @(posedge mclk);
      #1;
      // Request is a one-cycle pulse; a longer one would be a second access
      param_req = 1'b0;
      // Registered answer stands here until the answer edge samples it
      ack = param_ack;
      err = param_err;
      rdata = param_rdata;
      // Qualifiers stand until the answer edge has passed
      @(posedge mclk);
      #1;
   endtask
endmodule

// ===== tb.sv
module tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic mclk, rst, param_req, param_we, param_ack, param_err;
   logic [15:0] param_addr, param_wdata, param_rdata;
   logic [15:0] tx_pdo_count, rx_pdo_count, can_rx_err_cnt, can_tx_err_cnt;
   logic [1:0] nmt_state;
   logic [5:0] ev;
   logic comm_failure_event, boot_complete, motor_running;
   logic [2:0] error_resp_mode;
   logic comm_interrupt_error, coast_stop, fault_reset, node_reset, restart_busy;
   logic [31:0] seed;
   int error_cnt, checked, m_err, m_nmt, m_rst, n;
   localparam logic [15:0] ADDRS [7] = '{fieldbus_diag_pkg::ADDR_LAST_ERR, fieldbus_diag_pkg::ADDR_NMT_STATE,
      fieldbus_diag_pkg::ADDR_TX_ERR_CNT, fieldbus_diag_pkg::ADDR_RX_ERR_CNT, fieldbus_diag_pkg::ADDR_RESTART,
      fieldbus_diag_pkg::ADDR_TX_OBJ_CNT, fieldbus_diag_pkg::ADDR_RX_OBJ_CNT};

   fieldbus_diag_status_bank dut (.mclk(mclk), .rst(rst), .param_req(param_req), .param_we(param_we),
      .param_addr(param_addr), .param_wdata(param_wdata), .param_rdata(param_rdata), .param_ack(param_ack),
      .param_err(param_err), .nmt_state(nmt_state), .tx_pdo_count(tx_pdo_count), .rx_pdo_count(rx_pdo_count),
      .comm_start(ev[5]), .bus_off_event(ev[0]), .overrun_event(ev[2]), .guard_fail_event(ev[1]),
      .heartbeat_fail_event(ev[3]), .nmt_chart_event(ev[4]), .comm_failure_event(comm_failure_event),
      .boot_complete(boot_complete), .can_rx_err_cnt(can_rx_err_cnt), .can_tx_err_cnt(can_tx_err_cnt),
      .motor_running(motor_running), .error_resp_mode(error_resp_mode),
      .comm_interrupt_error(comm_interrupt_error), .coast_stop(coast_stop), .fault_reset(fault_reset),
      .node_reset(node_reset), .restart_busy(restart_busy));

   param_master master (.mclk(mclk), .param_req(param_req), .param_we(param_we), .param_addr(param_addr),
      .param_wdata(param_wdata), .param_rdata(param_rdata), .param_ack(param_ack), .param_err(param_err));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // ************************************************
   // Reference model and checking
   // ************************************************
   function automatic logic [15:0] rand_word();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction

   function automatic logic [15:0] expect_of(input logic [15:0] a);
      case (a)
         fieldbus_diag_pkg::ADDR_LAST_ERR: return 16'(m_err);
         fieldbus_diag_pkg::ADDR_NMT_STATE: return 16'(m_nmt);
         fieldbus_diag_pkg::ADDR_TX_ERR_CNT: return can_tx_err_cnt;
         fieldbus_diag_pkg::ADDR_RX_ERR_CNT: return can_rx_err_cnt;
         fieldbus_diag_pkg::ADDR_RESTART: return 16'(m_rst);
         fieldbus_diag_pkg::ADDR_TX_OBJ_CNT: return tx_pdo_count;
         fieldbus_diag_pkg::ADDR_RX_OBJ_CNT: return rx_pdo_count;
         // Unmapped read returns zero along with the error
         default: return 16'h0000;
      endcase
   endfunction

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic chk1(input string nm, input logic e, input logic s);
      chk(nm, {15'h0000, e}, {15'h0000, s});
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic e);
      logic [15:0] d;
      logic k, f;
      master.xfer(1'b0, a, 16'h0000, d, k, f);
      chk1("read ack", 1'b1, k);
      chk1("read err", e, f);
      chk("read data", expect_of(a), d);
   endtask

   task automatic wr_chk(input logic [15:0] a, input logic [15:0] w, input logic e);
      logic [15:0] d;
      logic k, f;
      master.xfer(1'b1, a, w, d, k, f);
      chk1("write ack", 1'b1, k);
      chk1("write err", e, f);
   endtask

   task automatic step(input int c);
      repeat (c) @(posedge mclk);
      #1;
   endtask

   task automatic fire(input logic [5:0] v, input int code);
      ev = v;
      step(1);
      ev = 6'h00;
      m_err = code;
      step(1);
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge mclk);
      error_cnt++;
      test_done();
   end

   // ************************************************
   // Main sequence
   // ************************************************
   initial begin
      rst = 1'b1;
      {nmt_state, ev, comm_failure_event, boot_complete, motor_running, error_resp_mode} = '0;
      {tx_pdo_count, rx_pdo_count, can_rx_err_cnt, can_tx_err_cnt} = '0;
      seed = 32'hF61F;
      error_cnt = 0;
      checked = 0;
      m_err = 0;
      m_nmt = 0;
      m_rst = 0;
      step(3);
      rst = 1'b0;
      for (int i = 0; i < 7; i++) begin
         rd_chk(ADDRS[i], 1'b0);
      end
      for (int i = 0; i < 4; i++) begin
         nmt_state = 2'(i);
         m_nmt = (i == 3) ? 4 : i;
         step(1);
         rd_chk(fieldbus_diag_pkg::ADDR_NMT_STATE, 1'b0);
      end
      chk1("comm error motor idle", 1'b0, comm_interrupt_error);
      for (int i = 0; i < 4; i++) begin
         tx_pdo_count = (i == 0) ? 16'hFFFF : rand_word();
         rx_pdo_count = (i == 0) ? 16'hFFFF : rand_word();
         can_rx_err_cnt = (i == 0) ? 16'hFFFF : rand_word();
         can_tx_err_cnt = (i == 0) ? 16'hFFFF : rand_word();
         step(1);
         rd_chk(fieldbus_diag_pkg::ADDR_TX_OBJ_CNT, 1'b0);
         rd_chk(fieldbus_diag_pkg::ADDR_RX_OBJ_CNT, 1'b0);
         rd_chk(fieldbus_diag_pkg::ADDR_RX_ERR_CNT, 1'b0);
         rd_chk(fieldbus_diag_pkg::ADDR_TX_ERR_CNT, 1'b0);
      end
      for (int i = 0; i < 7; i++) begin
         if (ADDRS[i] != fieldbus_diag_pkg::ADDR_RESTART) begin
            wr_chk(ADDRS[i], rand_word(), 1'b1);
            rd_chk(ADDRS[i], 1'b0);
         end
      end
      wr_chk(16'h17AC, rand_word(), 1'b1);
      rd_chk(16'h17AC, 1'b1);
      for (int k = 1; k <= 5; k++) begin
         fire(6'(1 << (k - 1)), k);
         rd_chk(fieldbus_diag_pkg::ADDR_LAST_ERR, 1'b0);
      end
      // Simultaneous causes: the higher code wins
      fire(6'h05, 3);
      rd_chk(fieldbus_diag_pkg::ADDR_LAST_ERR, 1'b0);
      fire(6'h20, 0);
      rd_chk(fieldbus_diag_pkg::ADDR_LAST_ERR, 1'b0);
      error_resp_mode = 3'h1;
      comm_failure_event = 1'b1;
      step(1);
      comm_failure_event = 1'b0;
      step(1);
      chk1("comm error freewheel", 1'b1, comm_interrupt_error);
      chk1("coast stop", 1'b1, coast_stop);
      wr_chk(fieldbus_diag_pkg::ADDR_RESTART, fieldbus_diag_pkg::RESTART_YES, 1'b0);
      m_rst = 1;
      chk1("fault reset", 1'b1, fault_reset);
      chk1("restart busy", 1'b1, restart_busy);
      step(1);
      chk1("fault reset end", 1'b0, fault_reset);
      chk1("comm error cleared", 1'b0, comm_interrupt_error);
      chk1("coast cleared", 1'b0, coast_stop);
      n = 0;
      while (node_reset === 1'b1 && n < 200) begin
         n++;
         step(1);
      end
      chk("hold cycles", 16'(fieldbus_diag_pkg::RESTART_HOLD_CYC), 16'(n));
      rd_chk(fieldbus_diag_pkg::ADDR_RESTART, 1'b0);
      boot_complete = 1'b1;
      step(1);
      boot_complete = 1'b0;
      n = 0;
      while (restart_busy !== 1'b0 && n < 10) begin
         n++;
         step(1);
      end
      step(1);
      m_rst = 0;
      chk1("busy after boot", 1'b0, restart_busy);
      rd_chk(fieldbus_diag_pkg::ADDR_RESTART, 1'b0);
      error_resp_mode = 3'h0;
      motor_running = 1'b1;
      nmt_state = 2'h1;
      m_nmt = 1;
      step(2);
      chk1("comm error nmt change", 1'b1, comm_interrupt_error);
      rd_chk(fieldbus_diag_pkg::ADDR_NMT_STATE, 1'b0);
      test_done();
   end
endmodule
